// [logic/palette_pkg.sv]
/*
 * Package for the palette lookup table: register offsets, field layout,
 * reset values, colour depth codes and the pixel carrier structs.
 * Assumes a byte-wide register port with eight-bit addresses.
 */
package palette_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_WRITE_BLUE_STAGE = 8'h08;
    localparam logic [7:0] OFS_WRITE_GREEN_STAGE = 8'h09;
    localparam logic [7:0] OFS_WRITE_RED_STAGE = 8'h0a;
    localparam logic [7:0] OFS_WRITE_INDEX = 8'h0b;
    localparam logic [7:0] OFS_READ_BLUE = 8'h0c;
    localparam logic [7:0] OFS_READ_GREEN = 8'h0d;
    localparam logic [7:0] OFS_READ_RED = 8'h0e;
    localparam logic [7:0] OFS_READ_INDEX = 8'h0f;
    localparam logic [7:0] OFS_PANEL_CONFIG = 8'h10;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int COMP_W = 6;
    localparam int COMP_LSB = 2;
    localparam int COMP_MSB = 7;
    localparam int ENTRIES = 256;
    localparam int PANEL_COLOUR_BIT = 6;
    localparam int DEPTH_LSB = 0;
    localparam int DEPTH_MSB = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_COMP = 6'h00;
    localparam logic [2:0] RST_DEPTH = 3'h0;

    // ------------------------------------------------------------
    // Colour depth codes in the panel configuration register
    // ------------------------------------------------------------
    localparam logic [2:0] DEPTH_1BPP = 3'h0;
    localparam logic [2:0] DEPTH_2BPP = 3'h1;
    localparam logic [2:0] DEPTH_4BPP = 3'h2;
    localparam logic [2:0] DEPTH_8BPP = 3'h3;
    localparam logic [2:0] DEPTH_16BPP = 3'h4;

    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } rgb_s;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } pixel_in_s;

    typedef struct packed {
        logic valid;
        rgb_s colour;
    } pixel_out_s;

endpackage

// [logic/palette_lookup_table.sv]
/*
 * Palette lookup table: 256 entries of six-bit red, green and blue,
 * staged host writes, pointer-triggered read-back, and the pixel path.
 * Assumes a single-cycle register port and pixels from the same clock.
 */
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module palette_lookup_table
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire palette_pkg::pixel_in_s pix_i,
    output palette_pkg::pixel_out_s pix_o
);

    // ------------------------------------------------------------
    // Register decode and staging
    // ------------------------------------------------------------
    logic [5:0] stage_blue_r;
    logic [5:0] stage_green_r;
    logic [5:0] stage_red_r;
    logic colour_panel_r;
    logic [2:0] depth_r;
    logic [5:0] back_blue_r;
    logic [5:0] back_green_r;
    logic [5:0] back_red_r;
    palette_pkg::rgb_s table_mem [palette_pkg::ENTRIES];
    logic wr_stage_b;
    logic wr_stage_g;
    logic wr_stage_r;
    logic wr_index;
    logic wr_read_index;
    logic wr_panel;

    assign wr_stage_b = reg_wr_i && reg_addr_i == palette_pkg::OFS_WRITE_BLUE_STAGE;
    assign wr_stage_g = reg_wr_i && reg_addr_i == palette_pkg::OFS_WRITE_GREEN_STAGE;
    assign wr_stage_r = reg_wr_i && reg_addr_i == palette_pkg::OFS_WRITE_RED_STAGE;
    assign wr_index = reg_wr_i && reg_addr_i == palette_pkg::OFS_WRITE_INDEX;
    assign wr_read_index = reg_wr_i && reg_addr_i == palette_pkg::OFS_READ_INDEX;
    assign wr_panel = reg_wr_i && reg_addr_i == palette_pkg::OFS_PANEL_CONFIG;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stage_blue_r <= palette_pkg::RST_COMP;
            stage_green_r <= palette_pkg::RST_COMP;
            stage_red_r <= palette_pkg::RST_COMP;
        end
        else
        begin
            // Low two bits of each byte are dropped
            if (wr_stage_b)
            begin
                stage_blue_r <= reg_wdata_i[palette_pkg::COMP_MSB:palette_pkg::COMP_LSB];
            end
            if (wr_stage_g)
            begin
                stage_green_r <= reg_wdata_i[palette_pkg::COMP_MSB:palette_pkg::COMP_LSB];
            end
            if (wr_stage_r)
            begin
                stage_red_r <= reg_wdata_i[palette_pkg::COMP_MSB:palette_pkg::COMP_LSB];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            colour_panel_r <= 1'b0;
            depth_r <= palette_pkg::RST_DEPTH;
        end
        else if (wr_panel)
        begin
            colour_panel_r <= reg_wdata_i[palette_pkg::PANEL_COLOUR_BIT];
            depth_r <= reg_wdata_i[palette_pkg::DEPTH_MSB:palette_pkg::DEPTH_LSB];
        end
    end

    // ------------------------------------------------------------
    // Table write: commit on write index only
    // ------------------------------------------------------------
    // Entries are not reset: software must load every entry that the
    // current depth can reach before the pixel path shows it.
    always_ff @(posedge sys_clk_i)
    begin
        if (wr_index)
        begin
            table_mem[reg_wdata_i] <= '{red: stage_red_r, green: stage_green_r,
                                        blue: stage_blue_r};
        end
    end

    // ------------------------------------------------------------
    // Read-back: loaded only by the read index write
    // ------------------------------------------------------------
    // The table is sampled at the end of the write cycle, so a commit in the
    // same cycle to the same entry is not yet visible.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            back_blue_r <= palette_pkg::RST_COMP;
            back_green_r <= palette_pkg::RST_COMP;
            back_red_r <= palette_pkg::RST_COMP;
        end
        else if (wr_read_index)
        begin
            back_blue_r <= table_mem[reg_wdata_i].blue;
            back_green_r <= table_mem[reg_wdata_i].green;
            back_red_r <= table_mem[reg_wdata_i].red;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reg_rdata_o <= palette_pkg::RST_BYTE;
        end
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                palette_pkg::OFS_READ_BLUE:
                    reg_rdata_o <= {back_blue_r, 2'b00};
                palette_pkg::OFS_READ_GREEN:
                    reg_rdata_o <= {back_green_r, 2'b00};
                palette_pkg::OFS_READ_RED:
                    reg_rdata_o <= {back_red_r, 2'b00};
                palette_pkg::OFS_PANEL_CONFIG:
                    reg_rdata_o <= {1'b0, colour_panel_r, 3'b000, depth_r};
                // Read index and all write-only or unmapped addresses read zero
                default:
                    reg_rdata_o <= palette_pkg::RST_BYTE;
            endcase
        end
        else
        begin
            reg_rdata_o <= palette_pkg::RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Pixel path
    // ------------------------------------------------------------
    logic [7:0] pix_index;
    palette_pkg::rgb_s entry;
    palette_pkg::rgb_s direct;

    always_comb
    begin
        // Depth limits which entries are reachable
        // Unused depth codes fall back to the full eight-bit index
        unique case (depth_r)
            palette_pkg::DEPTH_1BPP: pix_index = {7'h00, pix_i.value[0]};
            palette_pkg::DEPTH_2BPP: pix_index = {6'h00, pix_i.value[1:0]};
            palette_pkg::DEPTH_4BPP: pix_index = {4'h0, pix_i.value[3:0]};
            default: pix_index = pix_i.value[7:0];
        endcase
    end

    assign entry = table_mem[pix_index];
    // 5-6-5 pixel widened to six bits per component
    assign direct = '{red: {pix_i.value[15:11], 1'b0}, green: pix_i.value[10:5],
                      blue: {pix_i.value[4:0], 1'b0}};

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pix_o <= '0;
        end
        else
        begin
            // Mono copies one grey level onto all three outputs
            pix_o.valid <= pix_i.valid;
            if (depth_r == palette_pkg::DEPTH_16BPP)
            begin
                if (colour_panel_r)
                begin
                    pix_o.colour <= direct;
                end
                else
                begin
                    pix_o.colour <= '{red: direct.green, green: direct.green,
                                      blue: direct.green};
                end
            end
            else if (colour_panel_r)
            begin
                pix_o.colour <= entry;
            end
            else
            begin
                pix_o.colour <= '{red: entry.green, green: entry.green,
                                  blue: entry.green};
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic wr_read_index_q;
    logic [7:0] read_index_q;
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_read_index_q <= 1'b0;
            read_index_q <= palette_pkg::RST_BYTE;
        end
        else
        begin
            wr_read_index_q <= wr_read_index;
            read_index_q <= reg_wdata_i;
        end
    end

    // Last committed entry, so staging writes can be shown to leave it alone
    logic commit_seen_q;
    logic [7:0] last_commit_q;
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            commit_seen_q <= 1'b0;
            last_commit_q <= palette_pkg::RST_BYTE;
        end
        else if (wr_index)
        begin
            commit_seen_q <= 1'b1;
            last_commit_q <= reg_wdata_i;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------
    read_index_zero_a: assert property (
        reg_rd_i && reg_addr_i == palette_pkg::OFS_READ_INDEX |=> reg_rdata_o == 8'h00)
        else $error("read index did not read zero");
    back_hold_a: assert property (
        !wr_read_index |=> $stable(back_blue_r) && $stable(back_green_r) && $stable(back_red_r))
        else $error("read-back changed without index write");
    back_load_a: assert property (
        wr_read_index_q |-> back_green_r == table_mem[read_index_q].green
        && back_blue_r == table_mem[read_index_q].blue
        && back_red_r == table_mem[read_index_q].red)
        else $error("read-back not loaded");
    blue_pos_a: assert property (
        reg_rd_i && reg_addr_i == palette_pkg::OFS_READ_BLUE
        |=> reg_rdata_o == {$past(back_blue_r), 2'b00})
        else $error("blue read-back misplaced");
    green_pos_a: assert property (
        reg_rd_i && reg_addr_i == palette_pkg::OFS_READ_GREEN
        |=> reg_rdata_o == {$past(back_green_r), 2'b00})
        else $error("green read-back misplaced");
    red_pos_a: assert property (
        reg_rd_i && reg_addr_i == palette_pkg::OFS_READ_RED
        |=> reg_rdata_o[1:0] == 2'b00 && reg_rdata_o[7:2] == $past(back_red_r))
        else $error("red read-back misplaced");
    stage_trunc_a: assert property (
        wr_stage_g |=> stage_green_r == $past(reg_wdata_i[7:2]))
        else $error("staged green not truncated");
    stage_hold_a: assert property (
        !(wr_stage_b || wr_stage_g || wr_stage_r)
        |=> $stable(stage_blue_r) && $stable(stage_green_r) && $stable(stage_red_r))
        else $error("staged component changed without its write");
    entry_hold_a: assert property (
        commit_seen_q && !wr_index
        |=> table_mem[last_commit_q] == $past(table_mem[last_commit_q]))
        else $error("table entry changed without index write");
    commit_a: assert property (
        wr_index |=> table_mem[$past(reg_wdata_i)].red == $past(stage_red_r)
        && table_mem[$past(reg_wdata_i)].green == $past(stage_green_r))
        else $error("write index did not commit");

    // ------------------------------------------------------------
    // Pixel path checks
    // ------------------------------------------------------------
    mono_green_a: assert property (
        !colour_panel_r && $stable(colour_panel_r) && pix_i.valid
        |=> pix_o.colour.red == pix_o.colour.green && pix_o.colour.blue == pix_o.colour.green)
        else $error("mono output not from green");
    lut_index_a: assert property (
        colour_panel_r && depth_r == palette_pkg::DEPTH_8BPP && pix_i.valid
        |=> pix_o.colour == $past(table_mem[pix_i.value[7:0]]))
        else $error("pixel value did not select its entry");
    low_depth_a: assert property (
        !colour_panel_r && depth_r == palette_pkg::DEPTH_1BPP && pix_i.valid
        |=> pix_o.colour.green == $past(table_mem[{7'h00, pix_i.value[0]}].green))
        else $error("1 bpp mono reached past the first two entries");
    colour_depth_a: assert property (
        colour_panel_r && depth_r == palette_pkg::DEPTH_4BPP && pix_i.valid
        |=> pix_o.colour == $past(table_mem[{4'h0, pix_i.value[3:0]}]))
        else $error("4 bpp colour reached past the first sixteen entries");
    bypass_a: assert property (
        depth_r == palette_pkg::DEPTH_16BPP && colour_panel_r && !wr_panel
        |=> pix_o.colour.green == $past(pix_i.value[10:5]))
        else $error("16 bpp colour not bypassed");
    mono_bypass_a: assert property (
        !colour_panel_r && depth_r == palette_pkg::DEPTH_16BPP
        |=> pix_o.colour.green == $past(pix_i.value[10:5]))
        else $error("16 bpp mono not taken from pixel green");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    cov_commit_c: cover property (wr_index ##[1:4] wr_read_index);
    cov_mono8_c: cover property (!colour_panel_r && depth_r == palette_pkg::DEPTH_8BPP
        && pix_i.valid);
    cov_colour4_c: cover property (colour_panel_r && depth_r == palette_pkg::DEPTH_4BPP
        && pix_i.valid);
    cov_readback_c: cover property (wr_read_index ##1 reg_rd_i
        && reg_addr_i == palette_pkg::OFS_READ_BLUE);
    cov_mono16_c: cover property (!colour_panel_r && depth_r == palette_pkg::DEPTH_16BPP
        && pix_i.valid);

endmodule // palette_lookup_table

// [test/tb_top.sv]
/*
 * Self-checking bench for the palette lookup table: register access,
 * staged writes, pointer read-back and the pixel path in every mode.
 * Assumes the single-cycle register port and registered pixel output.
 */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    palette_pkg::pixel_in_s pix_i = '0;
    palette_pkg::pixel_out_s pix_o;
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] idx_list [5] = '{8'h00, 8'h01, 8'h03, 8'h13, 8'hff};
    logic [7:0] msk [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};

    always #25 sys_clk_i = ~sys_clk_i;

    palette_lookup_table dut
    (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .pix_i(pix_i),
        .pix_o(pix_o)
    );

    // ----------------------------------------------------------------
    // Colour bytes per entry, low bits set in some so truncation shows
    // ----------------------------------------------------------------
    function automatic logic [7:0] bb(input logic [7:0] i);
        bb = i + 8'h17;
    endfunction
    function automatic logic [7:0] gb(input logic [7:0] i);
        gb = i ^ 8'ha5;
    endfunction
    function automatic logic [7:0] rb(input logic [7:0] i);
        rb = ~i;
    endfunction
    function automatic palette_pkg::rgb_s ent(input logic [7:0] i, input logic mono);
        logic [7:0] b;
        logic [7:0] g;
        logic [7:0] r;
        b = bb(i);
        g = gb(i);
        r = rb(i);
        if (mono)
            ent = '{red: g[7:2], green: g[7:2], blue: g[7:2]};
        else
            ent = '{red: r[7:2], green: g[7:2], blue: b[7:2]};
    endfunction

    // ----------------------------------------------------------------
    // Compare, bus and pixel tasks
    // ----------------------------------------------------------------
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_pix(input string name, input palette_pkg::pixel_out_s exp,
                           input palette_pkg::pixel_out_s got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Strobe stays high so back-to-back writes need no idle cycle; rd and pix lower it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        reg_addr_i <= a;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        cmp8(name, exp, reg_rdata_o);
        @(posedge sys_clk_i);
    endtask
    task automatic pix(input logic [15:0] v, input palette_pkg::rgb_s exp, input string name);
        reg_wr_i <= 1'b0;
        pix_i <= '{valid: 1'b1, value: v};
        @(posedge sys_clk_i);
        pix_i <= '0;
        #1;
        cmp_pix(name, '{valid: 1'b1, colour: exp}, pix_o);
        @(posedge sys_clk_i);
    endtask
    task automatic put(input logic [7:0] i);
        wr(palette_pkg::OFS_WRITE_BLUE_STAGE, bb(i));
        wr(palette_pkg::OFS_WRITE_GREEN_STAGE, gb(i));
        wr(palette_pkg::OFS_WRITE_RED_STAGE, rb(i));
        wr(palette_pkg::OFS_WRITE_INDEX, i);
    endtask
    task automatic chk_rb(input logic [7:0] i);
        wr(palette_pkg::OFS_READ_INDEX, i);
        rd(palette_pkg::OFS_READ_BLUE, bb(i) & 8'hfc, "blue");
        rd(palette_pkg::OFS_READ_GREEN, gb(i) & 8'hfc, "green");
        rd(palette_pkg::OFS_READ_RED, rb(i) & 8'hfc, "red");
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial
    begin
        #(50 * 2000);
        error_cnt++;
        close_out();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(palette_pkg::OFS_PANEL_CONFIG, 8'h00, "config reset");
        rd(palette_pkg::OFS_READ_BLUE, 8'h00, "readback reset");
        $display("Test reset done");
        foreach (idx_list[k]) put(idx_list[k]);
        foreach (idx_list[k]) chk_rb(idx_list[k]);
        $display("Test entries done");
        wr(palette_pkg::OFS_WRITE_BLUE_STAGE, 8'h11);
        wr(palette_pkg::OFS_WRITE_GREEN_STAGE, 8'h22);
        wr(palette_pkg::OFS_WRITE_RED_STAGE, 8'h33);
        chk_rb(8'h13);
        wr(palette_pkg::OFS_WRITE_INDEX, 8'h13);
        wr(palette_pkg::OFS_READ_BLUE, 8'hff);
        rd(palette_pkg::OFS_READ_BLUE, bb(8'h13) & 8'hfc, "held blue");
        rd(palette_pkg::OFS_READ_INDEX, 8'h00, "read index");
        rd(palette_pkg::OFS_WRITE_INDEX, 8'h00, "write index");
        rd(8'h20, 8'h00, "unmapped");
        wr(palette_pkg::OFS_READ_INDEX, 8'h13);
        rd(palette_pkg::OFS_READ_BLUE, 8'h10, "new blue");
        rd(palette_pkg::OFS_READ_GREEN, 8'h20, "new green");
        rd(palette_pkg::OFS_READ_RED, 8'h30, "new red");
        put(8'h13);
        $display("Test staging done");
        for (int c = 0; c < 2; c++)
        begin
            for (int d = 0; d < 4; d++)
            begin
                wr(palette_pkg::OFS_PANEL_CONFIG, {1'b0, c[0], 3'b000, d[2:0]});
                pix(16'hab13, ent(8'h13 & msk[d], c == 0), "lut pixel");
            end
        end
        wr(palette_pkg::OFS_PANEL_CONFIG, {5'b01000, palette_pkg::DEPTH_16BPP});
        rd(palette_pkg::OFS_PANEL_CONFIG, {5'b01000, palette_pkg::DEPTH_16BPP}, "config");
        pix(16'hab13, '{red: 6'h2a, green: 6'h18, blue: 6'h26}, "colour 16");
        wr(palette_pkg::OFS_PANEL_CONFIG, {5'b00000, palette_pkg::DEPTH_16BPP});
        pix(16'hab13, '{red: 6'h18, green: 6'h18, blue: 6'h18}, "mono 16");
        $display("Test pixel done");
        close_out();
    end
endmodule // tb_top
